// file: dv/second_stage_loop_cfg_sva.sv
`timescale 1ns/1ns
module second_stage_loop_cfg_sva (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_wr_en,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_pfd_ref,
    input wire logic i_pfd_fb,
    input wire logic o_ref_edge,
    input wire logic o_fb_edge,
    input wire logic o_presc_running,
    input wire logic [2:0] o_presc_divide,
    input wire logic [11:0] o_second_pole_resistor_ohms,
    input wire logic [11:0] o_zero_resistor_ohms,
    input wire logic [5:0] o_first_pole_capacitor_pf,
    input wire logic o_first_pole_capacitor_known
);
    localparam logic [11:0] rp[4] = '{12'h384, 12'h1c2, 12'h12c, 12'h0e1};
    localparam logic [11:0] rz[8] = '{12'hcb2, 12'habe, 12'h8ca, 12'h834,
        12'hbb8, 12'h9c4, 12'h7d0, 12'h73a};
    logic [7:0] p_r;
    logic [7:0] l_r;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    // Shadow copies of both registers
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            p_r <= 8'h00;
            l_r <= 8'h00;
        end else if (i_wr_en) begin
            if (i_addr == 16'h0204) p_r <= i_wr_data & 8'h3f;
            if (i_addr == 16'h0205) l_r <= i_wr_data;
        end
    end
    // Pin change toward the selected edge
    sequence ref_act;
        $changed(i_pfd_ref) ##0 (i_pfd_ref ^ p_r[5]);
    endsequence
    sequence fb_act;
        $changed(i_pfd_fb) ##0 (i_pfd_fb ^ p_r[4]);
    endsequence
    a_ref_edge_pick: assert property (ref_act |-> ##3 o_ref_edge)
        else $error("reference edge pulse missing");
    a_fb_edge_pick: assert property (fb_act |-> ##3 o_fb_edge)
        else $error("feedback edge pulse missing");
    a_presc_power_state: assert property (o_presc_running ==
        (!$past(p_r[3]) && $past(p_r[2:0]) inside {[3:5]})) else $error("running wrong");
    a_ratio_decode: assert property (o_presc_divide ==
        ($past(p_r[2:0]) inside {[3:5]} ? $past(p_r[2:0]) : 3'h0)) else $error("divide wrong");
    // Filter outputs still show their reset value at the first edge after release
    a_pole_res_map: assert property (!$past(i_srst) |->
        o_second_pole_resistor_ohms == rp[$past(l_r[7:6])]) else $error("pole resistor wrong");
    a_zero_res_map: assert property (!$past(i_srst) |->
        o_zero_resistor_ohms == rz[$past(l_r[5:3])]) else $error("zero resistor wrong");
    a_cap_map: assert property (!$past(i_srst) |->
        {o_first_pole_capacitor_known, o_first_pole_capacitor_pf} ==
        ($past(l_r[2:0]) < 3 ? {1'b1, $past(l_r[2:0]), 3'h0} : 7'h00)) else $error("cap wrong");
endmodule

bind second_stage_loop_divider_filter_config second_stage_loop_cfg_sva second_stage_loop_cfg_sva_inst (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_wr_en(i_wr_en),
    .i_addr(i_addr),
    .i_wr_data(i_wr_data),
    .i_pfd_ref(i_pfd_ref),
    .i_pfd_fb(i_pfd_fb),
    .o_ref_edge(o_ref_edge),
    .o_fb_edge(o_fb_edge),
    .o_presc_running(o_presc_running),
    .o_presc_divide(o_presc_divide),
    .o_second_pole_resistor_ohms(o_second_pole_resistor_ohms),
    .o_zero_resistor_ohms(o_zero_resistor_ohms),
    .o_first_pole_capacitor_pf(o_first_pole_capacitor_pf),
    .o_first_pole_capacitor_known(o_first_pole_capacitor_known)
);

// file: dv/testbench.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module testbench;
    localparam logic [11:0] rp[4] = '{12'h384, 12'h1c2, 12'h12c, 12'h0e1};
    localparam logic [11:0] rz[8] = '{12'hcb2, 12'habe, 12'h8ca, 12'h834,
        12'hbb8, 12'h9c4, 12'h7d0, 12'h73a};
    logic i_clk_sys = 0, i_srst = 1, i_wr_en = 0, i_rd_en = 0;
    logic i_pfd_ref = 0, i_pfd_fb = 0, i_vco_tick = 0;
    logic [15:0] i_addr = 16'h0000;
    logic [7:0] i_wr_data = 8'h00;
    logic [7:0] o_rd_data;
    logic o_rd_valid, o_ref_edge, o_fb_edge, o_presc_tick, o_presc_running;
    logic [2:0] o_presc_divide;
    logic [11:0] o_second_pole_resistor_ohms, o_zero_resistor_ohms;
    logic [5:0] o_first_pole_capacitor_pf;
    logic o_first_pole_capacitor_known;
    logic [6:0] cap_seen;
    int mismatches = 0, compares = 0, cyc = 0, nref = 0, nfb = 0, ntk = 0;
    second_stage_loop_divider_filter_config second_stage_loop_divider_filter_config_inst (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_wr_en(i_wr_en),
        .i_rd_en(i_rd_en),
        .i_addr(i_addr),
        .i_wr_data(i_wr_data),
        .o_rd_data(o_rd_data),
        .o_rd_valid(o_rd_valid),
        .i_pfd_ref(i_pfd_ref),
        .i_pfd_fb(i_pfd_fb),
        .o_ref_edge(o_ref_edge),
        .o_fb_edge(o_fb_edge),
        .i_vco_tick(i_vco_tick),
        .o_presc_tick(o_presc_tick),
        .o_presc_running(o_presc_running),
        .o_presc_divide(o_presc_divide),
        .o_second_pole_resistor_ohms(o_second_pole_resistor_ohms),
        .o_zero_resistor_ohms(o_zero_resistor_ohms),
        .o_first_pole_capacitor_pf(o_first_pole_capacitor_pf),
        .o_first_pole_capacitor_known(o_first_pole_capacitor_known)
    );
    assign cap_seen = {o_first_pole_capacitor_known, o_first_pole_capacitor_pf};
    initial forever #2 i_clk_sys = ~i_clk_sys;
    // Pulse counters and hang limit, sampled mid-cycle
    always @(negedge i_clk_sys) begin
        cyc++;
        nref += o_ref_edge;
        nfb += o_fb_edge;
        ntk += o_presc_tick;
        if (cyc == 2000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_wr_en <= 1;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_clk_sys);
        i_wr_en <= 0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge i_clk_sys);
        i_rd_en <= 1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd_en <= 0;
        // Answer stands for the one cycle after the taking edge
        @(negedge i_clk_sys);
        `CHK("read", {1'b1, e}, {o_rd_valid, o_rd_data})
    endtask
    task automatic report_and_stop();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge i_clk_sys);
        i_srst <= 0;
        rd(16'h0205, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(16'h0205, {i[1:0], i[2:0], i[2:0]});
            // Decoded outputs follow the register by one cycle
            @(posedge i_clk_sys);
            @(negedge i_clk_sys);
            `CHK("pole", rp[i % 4], o_second_pole_resistor_ohms)
            `CHK("zero", rz[i], o_zero_resistor_ohms)
            `CHK("cap", i < 3 ? {1'b1, 6'(i * 8)} : 7'h00, cap_seen)
            rd(16'h0205, {i[1:0], i[2:0], i[2:0]});
        end
        $display("loop filter test done");
        wr(16'h0204, 8'hff);
        rd(16'h0204, 8'h3f);
        for (int n = 3; n < 6; n++) begin
            wr(16'h0204, 8'(n));
            @(posedge i_clk_sys);
            @(negedge i_clk_sys);
            `CHK("divide", 3'(n), o_presc_divide)
            `CHK("running", 1'b1, o_presc_running)
            ntk = 0;
            @(posedge i_clk_sys);
            i_vco_tick <= 1;
            repeat (4 * n) @(posedge i_clk_sys);
            i_vco_tick <= 0;
            repeat (3) @(posedge i_clk_sys);
            `CHK("ticks", 4, ntk)
        end
        wr(16'h0204, 8'h0b);
        ntk = 0;
        i_vco_tick <= 1;
        repeat (12) @(posedge i_clk_sys);
        i_vco_tick <= 0;
        @(negedge i_clk_sys);
        `CHK("pd ticks", 0, ntk)
        `CHK("pd running", 1'b0, o_presc_running)
        $display("prescaler test done");
        for (int m = 0; m < 4; m++) begin
            wr(16'h0204, 8'(m * 16 + 3));
            nref = 0;
            nfb = 0;
            i_pfd_ref <= 1;
            i_pfd_fb <= 1;
            repeat (6) @(posedge i_clk_sys);
            `CHK("ref rise", 32'(!m[1]), nref)
            `CHK("fb rise", 32'(!m[0]), nfb)
            i_pfd_ref <= 0;
            i_pfd_fb <= 0;
            repeat (6) @(posedge i_clk_sys);
            `CHK("ref total", 1, nref)
            `CHK("fb total", 1, nfb)
        end
        $display("edge select test done");
        wr(16'h0206, 8'h55);
        rd(16'h0206, 8'h00);
        rd(16'h0204, 8'h33);
        $display("unmapped test done");
        report_and_stop();
    end
endmodule

// file: rtl/second_stage_loop_cfg.svh
`ifndef SECOND_STAGE_LOOP_CFG_SVH
`define SECOND_STAGE_LOOP_CFG_SVH

// Register offsets
`define SECOND_STAGE_LOOP_PRESC_OFFSET 16'h0204
`define SECOND_STAGE_LOOP_LOOPF_OFFSET 16'h0205

// Reset values
`define SECOND_STAGE_LOOP_PRESC_RESET 8'h00
`define SECOND_STAGE_LOOP_LOOPF_RESET 8'h00

// Prescaler register fields
`define SECOND_STAGE_LOOP_REF_EDGE_BIT 5
`define SECOND_STAGE_LOOP_FB_EDGE_BIT 4
`define SECOND_STAGE_LOOP_PRESC_PD_BIT 3
`define SECOND_STAGE_LOOP_RATIO_MSB 2
`define SECOND_STAGE_LOOP_RATIO_LSB 0
`define SECOND_STAGE_LOOP_PRESC_WMASK 8'h3F

// Loop-filter register fields
`define SECOND_STAGE_LOOP_SECOND_POLE_RESISTOR_MSB 7
`define SECOND_STAGE_LOOP_SECOND_POLE_RESISTOR_LSB 6
`define SECOND_STAGE_LOOP_ZERO_RESISTOR_MSB 5
`define SECOND_STAGE_LOOP_ZERO_RESISTOR_LSB 3
`define SECOND_STAGE_LOOP_FIRST_POLE_CAPACITOR_MSB 2
`define SECOND_STAGE_LOOP_FIRST_POLE_CAPACITOR_LSB 0

`endif

// file: rtl/second_stage_loop_divider_filter_config.sv
`timescale 1ns/1ns
// Functional notes
// - Bit 5 picks reference edge, bit 4 feedback edge: 1 falling, 0 rising.
// - Bit 3 set powers down the VCO output prescaler; clear runs it only for ratio codes 011, 100 or 101.
// - Ratio bits 2:0 select divide by 3, 4 or 5 for codes 011, 100, 101.
// - Loop-filter bits 7:6 pick second-pole resistor 900, 450, 300, 225 ohms.
// - Loop-filter bits 5:3 pick zero resistor 3250 down to 1850 ohms table.
// - Loop-filter bits 2:0 pick first-pole capacitor 0, 8 or 16 pF.
`include "second_stage_loop_cfg.svh"

module second_stage_loop_divider_filter_config
    import second_stage_loop_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wr_data,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    input wire logic i_pfd_ref,
    input wire logic i_pfd_fb,
    output logic o_ref_edge,
    output logic o_fb_edge,
    input wire logic i_vco_tick,
    output logic o_presc_tick,
    output logic o_presc_running,
    output logic [2:0] o_presc_divide,
    output logic [11:0] o_second_pole_resistor_ohms,
    output logic [11:0] o_zero_resistor_ohms,
    output logic [5:0] o_first_pole_capacitor_pf,
    output logic o_first_pole_capacitor_known
);

    cfg_byte_t presc_r;
    cfg_byte_t loopf_r;

    logic ref_s1_r;
    logic ref_s2_r;
    logic ref_prev_r;
    logic fb_s1_r;
    logic fb_s2_r;
    logic fb_prev_r;

    logic [2:0] div_cnt_r;
    logic [2:0] divide;
    logic ratio_ok;

    // Chosen edge of a synchronised input
    function automatic logic edge_hit(input logic cur, input logic prev, input logic falling);
        edge_hit = falling ? (prev & ~cur) : (cur & ~prev);
    endfunction

    function automatic logic [2:0] ratio_divide(input logic [2:0] code);
        case (code)
            RATIO_DIV3: ratio_divide = 3'h3;
            RATIO_DIV4: ratio_divide = 3'h4;
            RATIO_DIV5: ratio_divide = 3'h5;
            default: ratio_divide = 3'h0;
        endcase
    endfunction

    function automatic ohms_t second_pole_resistor_ohms(input logic [1:0] code);
        case (code)
            2'b00: second_pole_resistor_ohms = 12'h384;
            2'b01: second_pole_resistor_ohms = 12'h1c2;
            2'b10: second_pole_resistor_ohms = 12'h12c;
            default: second_pole_resistor_ohms = 12'h0e1;
        endcase
    endfunction

    function automatic ohms_t zero_resistor_ohms(input logic [2:0] code);
        case (code)
            3'b000: zero_resistor_ohms = 12'hcb2;
            3'b001: zero_resistor_ohms = 12'habe;
            3'b010: zero_resistor_ohms = 12'h8ca;
            3'b011: zero_resistor_ohms = 12'h834;
            3'b100: zero_resistor_ohms = 12'hbb8;
            3'b101: zero_resistor_ohms = 12'h9c4;
            3'b110: zero_resistor_ohms = 12'h7d0;
            default: zero_resistor_ohms = 12'h73a;
        endcase
    endfunction

    function automatic pf_t first_pole_capacitor_pf(input logic [2:0] code);
        case (code)
            3'b000: first_pole_capacitor_pf = 6'h00;
            3'b001: first_pole_capacitor_pf = 6'h08;
            3'b010: first_pole_capacitor_pf = 6'h10;
            default: first_pole_capacitor_pf = 6'h00;
        endcase
    endfunction

    // Register writes; reserved prescaler bits are not stored
    // reserved bits dropped
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            presc_r <= `SECOND_STAGE_LOOP_PRESC_RESET;
            loopf_r <= `SECOND_STAGE_LOOP_LOOPF_RESET;
        end else if (i_wr_en) begin
            if (i_addr == `SECOND_STAGE_LOOP_PRESC_OFFSET) begin
                presc_r <= i_wr_data & `SECOND_STAGE_LOOP_PRESC_WMASK;
            end
            if (i_addr == `SECOND_STAGE_LOOP_LOOPF_OFFSET) begin
                loopf_r <= i_wr_data;
            end
        end
    end

    // Read data one cycle after the request; unmapped reads give zero
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_rd_data <= 8'h00;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_rd_en;
            if (i_rd_en) begin
                if (i_addr == `SECOND_STAGE_LOOP_PRESC_OFFSET) begin
                    o_rd_data <= presc_r;
                end else if (i_addr == `SECOND_STAGE_LOOP_LOOPF_OFFSET) begin
                    o_rd_data <= loopf_r;
                end else begin
                    o_rd_data <= 8'h00;
                end
            end
        end
    end

    // Detector inputs come from pins: two-stage synchronisers
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            ref_s1_r <= 1'b0;
            ref_s2_r <= 1'b0;
            ref_prev_r <= 1'b0;
            fb_s1_r <= 1'b0;
            fb_s2_r <= 1'b0;
            fb_prev_r <= 1'b0;
        end else begin
            ref_s1_r <= i_pfd_ref;
            ref_s2_r <= ref_s1_r;
            ref_prev_r <= ref_s2_r;
            fb_s1_r <= i_pfd_fb;
            fb_s2_r <= fb_s1_r;
            fb_prev_r <= fb_s2_r;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_ref_edge <= 1'b0;
            o_fb_edge <= 1'b0;
        end else begin
            o_ref_edge <= edge_hit(ref_s2_r, ref_prev_r, presc_r[`SECOND_STAGE_LOOP_REF_EDGE_BIT]);
            o_fb_edge <= edge_hit(fb_s2_r, fb_prev_r, presc_r[`SECOND_STAGE_LOOP_FB_EDGE_BIT]);
        end
    end

    assign divide = ratio_divide(presc_r[`SECOND_STAGE_LOOP_RATIO_MSB:`SECOND_STAGE_LOOP_RATIO_LSB]);
    assign ratio_ok = (divide != 3'h0);

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            div_cnt_r <= 3'h0;
            o_presc_tick <= 1'b0;
        end else if (presc_r[`SECOND_STAGE_LOOP_PRESC_PD_BIT] || !ratio_ok) begin
            div_cnt_r <= 3'h0;
            o_presc_tick <= 1'b0;
        end else if (i_vco_tick) begin
            // one output per N input ticks
            if (div_cnt_r >= divide - 3'h1) begin
                div_cnt_r <= 3'h0;
                o_presc_tick <= 1'b1;
            end else begin
                div_cnt_r <= div_cnt_r + 3'h1;
                o_presc_tick <= 1'b0;
            end
        end else begin
            o_presc_tick <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_presc_running <= 1'b0;
            o_presc_divide <= 3'h0;
        end else begin
            o_presc_running <= ~presc_r[`SECOND_STAGE_LOOP_PRESC_PD_BIT] & ratio_ok;
            o_presc_divide <= divide;
        end
    end

    // Loop-filter selections presented to the analog filter
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_second_pole_resistor_ohms <= 12'h000;
            o_zero_resistor_ohms <= 12'h000;
            o_first_pole_capacitor_pf <= 6'h00;
            o_first_pole_capacitor_known <= 1'b0;
        end else begin
            o_second_pole_resistor_ohms <=
                second_pole_resistor_ohms(loopf_r[`SECOND_STAGE_LOOP_SECOND_POLE_RESISTOR_MSB:`SECOND_STAGE_LOOP_SECOND_POLE_RESISTOR_LSB]);
            o_zero_resistor_ohms <= zero_resistor_ohms(loopf_r[`SECOND_STAGE_LOOP_ZERO_RESISTOR_MSB:`SECOND_STAGE_LOOP_ZERO_RESISTOR_LSB]);
            o_first_pole_capacitor_pf <=
                first_pole_capacitor_pf(loopf_r[`SECOND_STAGE_LOOP_FIRST_POLE_CAPACITOR_MSB:`SECOND_STAGE_LOOP_FIRST_POLE_CAPACITOR_LSB]);
            o_first_pole_capacitor_known <=
                (loopf_r[`SECOND_STAGE_LOOP_FIRST_POLE_CAPACITOR_MSB:`SECOND_STAGE_LOOP_FIRST_POLE_CAPACITOR_LSB] <= 3'b010);
        end
    end

endmodule

// file: rtl/second_stage_loop_pkg.sv
package second_stage_loop_pkg;

    typedef logic [7:0] cfg_byte_t;
    typedef logic [15:0] cfg_addr_t;

    typedef enum logic [2:0] {
        RATIO_DIV3 = 3'b011,
        RATIO_DIV4 = 3'b100,
        RATIO_DIV5 = 3'b101
    } ratio_code_e;

    typedef logic [11:0] ohms_t;
    typedef logic [5:0] pf_t;

endpackage
